/* File: core/bus_ports.sv */
// port and external memory bus logic
`timescale 1ns/1ns
module bus_ports
  import bus_ports_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             REF_CLK,
  input  wire logic             RESET_N,
  input  wire logic             RST_PIN,
  input  wire logic             EXTERNAL_FETCH_SELECT,
  input  wire logic             LOCK_BIT_ONE,
  input  wire logic             FLASH_PROGRAM_PULSE_INPUT_MODE,
  input  wire logic             FLASH_VERIFY,
  input  wire logic [WIDTH-1:0] FLASH_VERIFY_DATA,
  input  wire logic             PORT_WR_EN,
  input  wire logic [1:0]       PORT_WR_SEL,
  input  wire logic [WIDTH-1:0] PORT_WR_DATA,
  input  wire logic             AUX_WR_EN,
  input  wire logic [WIDTH-1:0] AUX_WR_DATA,
  input  wire logic             BUS_REQ,
  input  wire logic [3:0]       BUS_KIND,
  input  wire logic [15:0]      BUS_ADDR,
  input  wire logic [WIDTH-1:0] BUS_WDATA,
  input  wire logic             BUS_WRITE,
  input  wire logic             MOVE_ACTIVE,
  input  wire logic             TIMER_TWO_CLK_OUT_EN,
  input  wire logic             TIMER_TWO_CLK_OUT,
  input  wire logic             SERIAL_TX,
  input  wire logic [WIDTH-1:0] P0_IN,
  input  wire logic [WIDTH-1:0] P1_IN,
  input  wire logic [WIDTH-1:0] P2_IN,
  input  wire logic [WIDTH-1:0] P3_IN,
  input  wire logic             STROBE_PIN_IN,
  output logic      [WIDTH-1:0] P0_OUT,
  output logic      [WIDTH-1:0] P0_OE_N,
  output logic      [WIDTH-1:0] P1_OUT,
  output logic      [WIDTH-1:0] P2_OUT,
  output logic      [WIDTH-1:0] P3_OUT,
  output logic      [WIDTH-1:0] PORT_RD_P0,
  output logic      [WIDTH-1:0] PORT_RD_P1,
  output logic      [WIDTH-1:0] PORT_RD_P2,
  output logic      [WIDTH-1:0] PORT_RD_P3,
  output logic      [WIDTH-1:0] BUS_RDATA,
  output logic                  ADDRESS_LATCH_STROBE,
  output logic                  STROBE_OE_N,
  output logic                  PROGRAM_FETCH_STROBE_N,
  output logic                  CODE_FROM_EXTERNAL,
  output logic                  CORE_RESET,
  output logic                  PROGRAM_PULSE_INPUT,
  output logic                  TIMER_TWO_COUNT_INPUT,
  output logic                  TIMER_TWO_TRIGGER_INPUT,
  output logic                  SERIAL_RX,
  output logic                  EXTERNAL_IRQ_ZERO,
  output logic                  EXTERNAL_IRQ_ONE,
  output logic                  TIMER_ZERO_INPUT,
  output logic                  TIMER_ONE_INPUT
);

  logic [3:0]       osc_cnt;
  logic [4:0]       rst_cnt;
  logic             rst_seen;
  logic [WIDTH-1:0] port_latch [4];
  logic [WIDTH-1:0] aux_reg;
  logic             fetch_latched;
  logic             fetch_latch_done;
  logic             strobe_off;
  acc_t             cyc_kind;
  logic [15:0]      cyc_addr;
  logic [WIDTH-1:0] cyc_wdata;
  logic             cyc_write;
  logic             slot_a;
  logic             addr_phase;
  logic             p0_addr;
  logic             data_cycle;
  logic             ale_want;
  logic             program_fetch_strobe_want;
  logic             ext_fetch;

  // oscillator periods within the machine cycle
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_cnt <= 4'h0;
    end else if (osc_cnt == 4'(OSC_PER_MC - 1)) begin
      osc_cnt <= 4'h0;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end

  // reset pin must stay high two whole machine cycles; shorter glitches are ignored
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_cnt  <= 5'h00;
      rst_seen <= 1'b1;
    end else if (!RST_PIN) begin
      rst_cnt  <= 5'h00;
      rst_seen <= 1'b0;
    end else if (rst_cnt == 5'(RST_HOLD_CYC - 1)) begin
      rst_seen <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 5'h01;
    end
  end
  assign CORE_RESET = rst_seen;

  // port latches reset to all ones so every pin starts as an input
  generate
    for (genvar p = 0; p < 4; p++) begin : g_latch
      always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          port_latch[p] <= PORT_RESET;
        end else if (rst_seen) begin
          port_latch[p] <= PORT_RESET;
        end else if (PORT_WR_EN && PORT_WR_SEL == 2'(p)) begin
          port_latch[p] <= PORT_WR_DATA;
        end
      end
    end
  endgenerate

  // auxiliary control register; unused bits forced to zero
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aux_reg <= AUX_RESET;
    end else if (rst_seen) begin
      aux_reg <= AUX_RESET;
    end else if (AUX_WR_EN) begin
      aux_reg <= AUX_WR_DATA & 8'h01;
    end
  end
  assign strobe_off = aux_reg[AUX_STROBE_OFF];

  // strap captured on the first clock after internal reset, used only when locked
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fetch_latched    <= 1'b0;
      fetch_latch_done <= 1'b0;
    end else if (rst_seen) begin
      fetch_latch_done <= 1'b0;
    end else if (!fetch_latch_done) begin
      fetch_latched    <= EXTERNAL_FETCH_SELECT;
      fetch_latch_done <= 1'b1;
    end
  end
  // select low means external code for the full 64k space
  assign ext_fetch = LOCK_BIT_ONE ? !fetch_latched : !EXTERNAL_FETCH_SELECT;
  assign CODE_FROM_EXTERNAL = ext_fetch;

  // capture one bus request per machine cycle at its start
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_kind  <= ACC_NONE;
      cyc_addr  <= 16'h0000;
      cyc_wdata <= 8'h00;
      cyc_write <= 1'b0;
    end else if (osc_cnt == 4'h0) begin
      cyc_kind  <= (BUS_REQ && !rst_seen) ? acc_t'(BUS_KIND) : ACC_NONE;
      cyc_addr  <= BUS_ADDR;
      cyc_wdata <= BUS_WDATA;
      cyc_write <= BUS_WRITE;
    end
  end

  // request taken at count 0 owns counts 1 to 11 and the next 0, so slots start at 1
  assign slot_a     = (osc_cnt != 4'h0) && (osc_cnt <= 4'(SLOT_LEN));
  assign addr_phase = (osc_cnt == 4'h1) || (osc_cnt == 4'(SLOT_LEN + 1));
  // a fetch shows its address under the second strobe too, else the latch takes a floating bus
  assign p0_addr    = slot_a || (addr_phase && cyc_kind == ACC_FETCH);
  assign data_cycle = (cyc_kind == ACC_DATA8) || (cyc_kind == ACC_DATA16);

  // strobe every six periods, one skipped in the second slot of a data cycle
  always_comb begin
    ale_want = addr_phase;
    if (data_cycle && !slot_a) begin
      ale_want = 1'b0;
    end
    if (strobe_off && !ext_fetch && !MOVE_ACTIVE) begin
      ale_want = 1'b0;
    end
  end

  // fetch strobe active low outside address phase, twice per cycle
  always_comb begin
    program_fetch_strobe_want = ext_fetch && !addr_phase && !rst_seen;
    if (data_cycle) begin
      program_fetch_strobe_want = 1'b0;
    end
  end

  // strobe outputs registered to keep glitches off the pins
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ADDRESS_LATCH_STROBE   <= 1'b1;
      STROBE_OE_N            <= 1'b1;
      PROGRAM_FETCH_STROBE_N <= 1'b1;
    end else begin
      ADDRESS_LATCH_STROBE   <= ale_want;
      // pin released to weak pullup when idle or during programming
      STROBE_OE_N            <= FLASH_PROGRAM_PULSE_INPUT_MODE || !ale_want;
      PROGRAM_FETCH_STROBE_N <= !program_fetch_strobe_want;
    end
  end
  assign PROGRAM_PULSE_INPUT = FLASH_PROGRAM_PULSE_INPUT_MODE & STROBE_PIN_IN;

  // port zero: address, data, verify or open-drain latch value
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      P0_OUT  <= PORT_RESET;
      P0_OE_N <= PORT_RESET;
    end else if (FLASH_PROGRAM_PULSE_INPUT_MODE) begin
      P0_OUT  <= FLASH_VERIFY_DATA;
      P0_OE_N <= FLASH_VERIFY ? 8'h00 : 8'hFF;
    end else if (cyc_kind != ACC_NONE) begin
      // bus role drives both levels, acting as pullups
      P0_OUT  <= p0_addr ? cyc_addr[7:0] : cyc_wdata;
      P0_OE_N <= (!p0_addr && (!cyc_write || cyc_kind == ACC_FETCH)) ? 8'hFF : 8'h00;
    end else begin
      P0_OUT  <= port_latch[0];
      P0_OE_N <= port_latch[0];
    end
  end

  // port two: high address byte or its latch
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      P2_OUT <= PORT_RESET;
    end else if (cyc_kind == ACC_FETCH || cyc_kind == ACC_DATA16) begin
      P2_OUT <= cyc_addr[15:8];
    end else begin
      P2_OUT <= port_latch[2];
    end
  end

  // ports one and three: quasi-bidirectional, alternate outputs and gated by latch
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      P1_OUT <= PORT_RESET;
      P3_OUT <= PORT_RESET;
    end else begin
      P1_OUT <= port_latch[1];
      if (TIMER_TWO_CLK_OUT_EN) begin
        P1_OUT[PT_COUNT] <= port_latch[1][PT_COUNT] & TIMER_TWO_CLK_OUT;
      end
      P3_OUT    <= port_latch[3];
      P3_OUT[1] <= port_latch[3][1] & SERIAL_TX;
      P3_OUT[P3_WR] <= port_latch[3][P3_WR] &
                       !(data_cycle && cyc_write && !slot_a);
      P3_OUT[P3_RD] <= port_latch[3][P3_RD] &
                       !(data_cycle && !cyc_write && !slot_a);
    end
  end

  // pin reads and alternate inputs
  assign PORT_RD_P0 = P0_IN;
  assign PORT_RD_P1 = P1_IN & P1_OUT;
  assign PORT_RD_P2 = P2_IN & P2_OUT;
  assign PORT_RD_P3 = P3_IN & P3_OUT;
  assign TIMER_TWO_COUNT_INPUT   = P1_IN[PT_COUNT];
  assign TIMER_TWO_TRIGGER_INPUT = P1_IN[PT_TRIG];
  assign SERIAL_RX         = P3_IN[0];
  assign EXTERNAL_IRQ_ZERO = P3_IN[2];
  assign EXTERNAL_IRQ_ONE  = P3_IN[3];
  assign TIMER_ZERO_INPUT  = P3_IN[4];
  assign TIMER_ONE_INPUT   = P3_IN[5];

  // read data sampled at end of the data slot
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS_RDATA <= 8'h00;
    end else if (cyc_kind != ACC_NONE && osc_cnt == 4'(OSC_PER_MC - 1)) begin
      BUS_RDATA <= P0_IN;
    end
  end

  // checks
  sequence s_data_cycle;
    data_cycle && osc_cnt == 4'(SLOT_LEN + 1);
  endsequence

  chk_reset_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (!RST_PIN ##1 RST_PIN [*8]) |-> !rst_seen)
    else $error("reset taken too early");
  chk_strobe_rate: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (!strobe_off && !data_cycle && addr_phase) |=> ADDRESS_LATCH_STROBE)
    else $error("strobe missing");
  chk_strobe_skip: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    s_data_cycle |=> !ADDRESS_LATCH_STROBE)
    else $error("strobe not skipped");
  chk_strobe_off: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (strobe_off && !ext_fetch && !MOVE_ACTIVE) |=> !ADDRESS_LATCH_STROBE)
    else $error("strobe not disabled");
  chk_strobe_ext: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ext_fetch && osc_cnt == 4'h1) |=> ADDRESS_LATCH_STROBE)
    else $error("strobe stopped in external mode");
  chk_fetch_skip: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    data_cycle |=> PROGRAM_FETCH_STROBE_N)
    else $error("fetch strobe in data cycle");
  chk_port2_addr: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (cyc_kind == ACC_DATA16) |=> P2_OUT == $past(cyc_addr[15:8]))
    else $error("high address wrong");
  chk_port2_latch: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (cyc_kind == ACC_DATA8) |=> P2_OUT == $past(port_latch[2]))
    else $error("port two latch not kept");
  chk_port0_float: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (cyc_kind == ACC_NONE && !FLASH_PROGRAM_PULSE_INPUT_MODE) |=> P0_OE_N == $past(port_latch[0]))
    else $error("port zero drive wrong");

endmodule

/* File: core/bus_ports_pkg.sv */
// constants and types for the port and external memory bus block
// Function
// - port zero is open drain; a one bit floats as a high-impedance input
// - port zero carries low address then data during external accesses, pulled up
// - ports one to three are 8-bit quasi-bidirectional with pullups; one bits read input
// - port one bits 0/1 serve timer-two count/clock-out and trigger inputs
// - port two drives high address byte on fetches and 16-bit data accesses
// - port two keeps its latch value during 8-bit-address data accesses
// - port three bits carry serial, irq, timer and read/write strobe functions
// - reset when reset input high for two machine cycles with oscillator running
// - latch strobe pulses to capture low address on each external access
// - latch strobe runs continuously at one sixth oscillator rate
// - exactly one latch strobe pulse omitted per external data access
// - strobe-disable bit limits strobe to data/code-table moves, else weak high
// - strobe-disable ignored while executing from external program memory
// - fetch strobe twice per machine cycle externally, two skipped per data access
// - fetch select low sends all code fetches external, high uses internal memory
// - with lock bit one programmed, fetch select is latched at reset
// - in flash programming port zero takes and returns bytes, strobe pin is pulse input
// - unimplemented special registers read arbitrary; future bits reset to zero
package bus_ports_pkg;
  localparam int unsigned OSC_PER_MC     = 12;
  localparam int unsigned SLOT_LEN       = 6;
  localparam int unsigned RST_HOLD_MC    = 2;
  localparam int unsigned RST_HOLD_CYC   = RST_HOLD_MC * OSC_PER_MC;
  localparam logic [7:0]  PORT_RESET     = 8'hFF;
  localparam logic [7:0]  AUX_RESET      = 8'h00;
  localparam int unsigned AUX_STROBE_OFF = 0;
  localparam int unsigned PT_COUNT       = 0;
  localparam int unsigned PT_TRIG        = 1;
  localparam int unsigned P3_WR          = 6;
  localparam int unsigned P3_RD          = 7;
  // what a machine cycle is doing on the bus
  typedef enum logic [3:0] {
    ACC_NONE  = 4'b0001,
    ACC_FETCH = 4'b0010,
    ACC_DATA8 = 4'b0100,
    ACC_DATA16 = 4'b1000
  } acc_t;
endpackage

/* File: testbench/ext_mem_model.sv */
// external memory with its address latch, seen from the bus pins
`timescale 1ns/1ns
module ext_mem_model (
  input  wire logic        REF_CLK,
  input  wire logic        ale,
  input  wire logic        fetch_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  p0_oe_n,
  input  wire logic [7:0]  p0_pin,
  input  wire logic [7:0]  p2_pin,
  output logic             drive,
  output logic [7:0]       drive_data,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data
);
  logic [7:0] low_addr;
  // latch follows port zero while the strobe is high
  always_ff @(posedge REF_CLK) begin
    if (ale) begin
      low_addr <= p0_pin;
    end
  end
  // write strobe low: keep the byte and the full address
  always_ff @(posedge REF_CLK) begin
    if (!wr_n) begin
      wr_addr <= {p2_pin, low_addr};
      wr_data <= p0_pin;
    end
  end
  // answer only once the device lets go of port zero, so the two never fight
  assign drive      = (!fetch_n || !rd_n) && (p0_oe_n == 8'hFF);
  assign drive_data = p2_pin ^ low_addr ^ 8'h5A;
endmodule

/* File: testbench/bus_ports_tb_top.sv */
// self-checking bench for the port and external bus block
`timescale 1ns/1ns
module bus_ports_tb_top;
  import bus_ports_pkg::*;
  typedef struct packed {
    logic [1:0] s;
    logic [7:0] d;
    logic [7:0] pin;
    logic [7:0] out;
    logic [7:0] rd;
  } row_t;
  logic        clk, rst_n, rst_pin, fsel, lock, fprog, fver, pwe, awe, breq, bwr;
  logic        move, t2en, t2o, stx, spin, drive;
  logic        ale, soe, program_fetch_strobe_n, cext, crst, ppi, t2c, t2t, srx, i0, i1, t0v, t1v;
  logic [1:0]  psel;
  logic [3:0]  bkind;
  logic [15:0] baddr, wr_addr;
  logic [7:0]  fdata, pwd, awd, bwd, tb_p0, tb_p1, tb_p2, tb_p3, drv_data, wr_data;
  logic [7:0]  p0o, p0oe, p1o, p2o, p3o, rd0, rd1, rd2, rd3, rdata;
  logic [7:0]  outs [4];
  logic [7:0]  rds [4];
  int          err_total, compares, cycles, c;
  // port zero wire: device drive wins, then memory, then pullup or bench
  wire  [7:0]  p0_pin = (~p0oe & p0o) | (p0oe & (drive ? drv_data : tb_p0));
  row_t rows [7] = '{'{2'd0, 8'hFF, 8'hA5, 8'hFF, 8'hA5}, '{2'd0, 8'h0F, 8'hFF, 8'h0F, 8'h0F},
    '{2'd1, 8'h5A, 8'hF0, 8'h5A, 8'h50}, '{2'd1, 8'hFF, 8'hFF, 8'hFF, 8'hFF},
    '{2'd2, 8'hC3, 8'hFF, 8'hC3, 8'hC3}, '{2'd3, 8'h96, 8'h3C, 8'h96, 8'h14},
    '{2'd3, 8'hFF, 8'hFF, 8'hFF, 8'hFF}};
  // port zero is seen through its enables, the others through levels
  always_comb outs = '{p0oe, p1o, p2o, p3o};
  always_comb rds = '{rd0, rd1, rd2, rd3};

  bus_ports uut (
    .REF_CLK(clk), .RESET_N(rst_n), .RST_PIN(rst_pin), .EXTERNAL_FETCH_SELECT(fsel),
    .LOCK_BIT_ONE(lock), .FLASH_PROGRAM_PULSE_INPUT_MODE(fprog), .FLASH_VERIFY(fver),
    .FLASH_VERIFY_DATA(fdata), .PORT_WR_EN(pwe), .PORT_WR_SEL(psel), .PORT_WR_DATA(pwd),
    .AUX_WR_EN(awe), .AUX_WR_DATA(awd), .BUS_REQ(breq), .BUS_KIND(bkind), .BUS_ADDR(baddr),
    .BUS_WDATA(bwd), .BUS_WRITE(bwr), .MOVE_ACTIVE(move), .TIMER_TWO_CLK_OUT_EN(t2en),
    .TIMER_TWO_CLK_OUT(t2o), .SERIAL_TX(stx), .P0_IN(p0_pin), .P1_IN(p1o & tb_p1),
    .P2_IN(p2o & tb_p2), .P3_IN(p3o & tb_p3), .STROBE_PIN_IN(spin), .P0_OUT(p0o),
    .P0_OE_N(p0oe), .P1_OUT(p1o), .P2_OUT(p2o), .P3_OUT(p3o), .PORT_RD_P0(rd0),
    .PORT_RD_P1(rd1), .PORT_RD_P2(rd2), .PORT_RD_P3(rd3), .BUS_RDATA(rdata),
    .ADDRESS_LATCH_STROBE(ale), .STROBE_OE_N(soe), .PROGRAM_FETCH_STROBE_N(program_fetch_strobe_n),
    .CODE_FROM_EXTERNAL(cext), .CORE_RESET(crst), .PROGRAM_PULSE_INPUT(ppi),
    .TIMER_TWO_COUNT_INPUT(t2c), .TIMER_TWO_TRIGGER_INPUT(t2t), .SERIAL_RX(srx),
    .EXTERNAL_IRQ_ZERO(i0), .EXTERNAL_IRQ_ONE(i1), .TIMER_ZERO_INPUT(t0v),
    .TIMER_ONE_INPUT(t1v)
  );
  ext_mem_model mem (
    .REF_CLK(clk), .ale(ale), .fetch_n(program_fetch_strobe_n), .rd_n(p3o[P3_RD]), .wr_n(p3o[P3_WR]),
    .p0_oe_n(p0oe), .p0_pin(p0_pin), .p2_pin(p2o), .drive(drive), .drive_data(drv_data),
    .wr_addr(wr_addr), .wr_data(wr_data)
  );

  // 10 MHz oscillator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, more than twelve times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      close_out();
    end
  end

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic count_ale(input int n, output int k);
    k = 0;
    repeat (n) begin
      tick(1);
      k += (ale === 1'b1);
    end
  endtask
  task automatic port_wr(input logic [1:0] s, input logic [7:0] d);
    psel = s;
    pwd = d;
    pwe = 1'b1;
    tick(1);
    pwe = 1'b0;
    tick(2);
  endtask
  task automatic aux_wr(input logic [7:0] d);
    awd = d;
    awe = 1'b1;
    tick(1);
    awe = 1'b0;
    tick(2);
  endtask
  // held 12 cycles so exactly one cycle-start edge takes it; 24 cycles span it whole
  task automatic bus_op(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d,
                        input logic w, output int n);
    int m;
    bkind = k;
    baddr = a;
    bwd = d;
    bwr = w;
    breq = 1'b1;
    count_ale(12, n);
    breq = 1'b0;
    count_ale(12, m);
    n += m;
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {rst_n, rst_pin, lock, fprog, fver, pwe, awe, breq, bwr, move, t2en, spin} = '0;
    {fsel, t2o, stx} = '1;
    {psel, bkind, baddr, fdata, pwd, awd, bwd} = '0;
    {tb_p0, tb_p1, tb_p2, tb_p3} = '1;
    tick(10);
    check({p1o, p2o}, 16'hFFFF);
    check({p3o, p0oe}, 16'hFFFF);
    check({program_fetch_strobe_n, soe, crst}, 3'b111);
    rst_n = 1'b1;
    tick(3);
    // ordinary port cases from the table
    foreach (rows[i]) begin
      {tb_p0, tb_p1, tb_p2, tb_p3} = {4{rows[i].pin}};
      port_wr(rows[i].s, rows[i].d);
      check(outs[rows[i].s], rows[i].out);
      check(rds[rows[i].s], rows[i].rd);
    end
    for (int i = 0; i < 2; i++) begin
      tb_p1 = i ? 8'hAA : 8'h55;
      tb_p3 = tb_p1;
      tick(1);
      check({t2t, t2c}, tb_p1[1:0]);
      check({t1v, t0v, i1, i0, srx}, {tb_p3[5:2], tb_p3[0]});
    end
    {tb_p1, tb_p3} = '1;
    {t2en, t2o, stx} = 3'b100;
    tick(2);
    check({p3o[1], p1o[0]}, 2'b00);
    {t2o, stx} = 2'b11;
    tick(2);
    check({p3o[1], p1o[0]}, 2'b11);
    count_ale(24, c);
    check(16'(c), 16'h0004);
    // external bus traffic against the memory model
    fsel = 1'b0;
    tick(2);
    bus_op(ACC_FETCH, 16'h1234, 8'h00, 1'b0, c);
    check(16'(c), 16'h0004);
    check(rdata, mem_byte(16'h1234));
    port_wr(2'd2, 8'h3C);
    bus_op(ACC_DATA8, 16'h0077, 8'h00, 1'b0, c);
    check(16'(c), 16'h0003);
    check(rdata, mem_byte(16'h3C77));
    bus_op(ACC_DATA16, 16'hA5C3, 8'h00, 1'b0, c);
    check(16'(c), 16'h0003);
    check(rdata, mem_byte(16'hA5C3));
    bus_op(ACC_DATA16, 16'hBEEF, 8'h96, 1'b1, c);
    check(wr_addr, 16'hBEEF);
    check(wr_data, 8'h96);
    // strobe disable, its move exception and the external-run override
    fsel = 1'b1;
    aux_wr(8'h01);
    count_ale(24, c);
    check(16'(c), 16'h0000);
    check(soe, 1'b1);
    move = 1'b1;
    count_ale(24, c);
    check(c > 0, 1'b1);
    move = 1'b0;
    fsel = 1'b0;
    tick(2);
    count_ale(24, c);
    check(16'(c), 16'h0004);
    aux_wr(8'h00);
    // flash programming pin reuse
    {fsel, fprog, spin} = 3'b111;
    tick(1);
    check(ppi, 1'b1);
    {spin, fver, fdata} = {2'b01, 8'h69};
    tick(2);
    check(ppi, 1'b0);
    check(p0_pin, 8'h69);
    {fver, fprog} = 2'b00;
    tick(2);
    // reset pin hold time, then strap latching
    port_wr(2'd1, 8'h00);
    rst_pin = 1'b1;
    tick(RST_HOLD_CYC - 4);
    check(crst, 1'b0);
    rst_pin = 1'b0;
    tick(4);
    {lock, fsel, rst_pin} = 3'b111;
    tick(RST_HOLD_CYC + 4);
    check({crst, p1o}, 9'h1FF);
    rst_pin = 1'b0;
    tick(3);
    fsel = 1'b0;
    tick(3);
    check(cext, 1'b0);
    lock = 1'b0;
    tick(3);
    check(cext, 1'b1);
    close_out();
  end
endmodule
